// >>> design/dpar_pkg.sv
// constants for the debug port abort, identification and base pointer registers
package dpar_pkg;
    // word index of register offset 0x0000 on the protocol engine access port
    localparam logic [1:0] DPAR_OFS_ZERO = 2'h0;

    // bank select values that steer offset zero reads
    localparam logic [3:0] DPAR_BANK_IDR = 4'h0;
    localparam logic [3:0] DPAR_BANK_IDR_EXT = 4'h1;
    localparam logic [3:0] DPAR_BANK_BASE_LO = 4'h2;
    localparam logic [3:0] DPAR_BANK_BASE_HI = 4'h3;

    // abort control bit positions
    localparam int DPAR_ABT_TRANS_BIT = 0;
    localparam int DPAR_ABT_STK_BIT = 2;
    localparam int DPAR_ABT_WDE_BIT = 3;
    localparam int DPAR_ABT_ORUN_BIT = 4;

    // identification fields; revision, part and designer values are arbitrary
    localparam logic [3:0] DPAR_ID_REVISION = 4'h1;
    localparam logic [7:0] DPAR_ID_PART = 8'h5a;
    localparam logic [10:0] DPAR_ID_DESIGNER = 11'h2c5;
    localparam logic [0:0] DPAR_ID_MIN = 1'h1;
    localparam logic [3:0] DPAR_ID_VERSION = 4'h3;
    localparam logic [0:0] DPAR_ID_READS_AS_ONE = 1'h1;
    localparam int DPAR_ID_MIN_BIT = 16;
    localparam int DPAR_ID_VER_LSB = 12;
    localparam int DPAR_ID_DES_LSB = 1;
    localparam logic [31:0] DPAR_IDR_WORD = {DPAR_ID_REVISION, DPAR_ID_PART, 3'h0,
        DPAR_ID_MIN, DPAR_ID_VERSION, DPAR_ID_DESIGNER, DPAR_ID_READS_AS_ONE};

    // second identification word: error mode support and address width code
    localparam logic [6:0] DPAR_AWIDTH_12 = 7'h0c;
    localparam logic [6:0] DPAR_AWIDTH_20 = 7'h14;
    localparam logic [6:0] DPAR_AWIDTH_32 = 7'h20;
    localparam logic [6:0] DPAR_AWIDTH = DPAR_AWIDTH_32;
    localparam logic [0:0] DPAR_ERR_REPORT_IMPL = 1'h1;
    localparam int DPAR_ERR_REPORT_BIT = 7;
    localparam logic [31:0] DPAR_IDR_EXT_WORD = {24'h000000, DPAR_ERR_REPORT_IMPL, DPAR_AWIDTH};

    // base pointer layout
    localparam int DPAR_BASE_LSB = 12;
    localparam int DPAR_BASE_VALID_BIT = 0;
    localparam logic [10:0] DPAR_BASE_LOW_ZERO = 11'h000;
    localparam logic [31:0] DPAR_BASE_HI_WORD = 32'h00000000;

    // reset values
    localparam logic [31:0] DPAR_RDATA_RST = 32'h00000000;
    localparam logic DPAR_STROBE_RST = 1'b0;
endpackage

// >>> design/dpar_sync.sv
// two flip-flop synchroniser for static tie-off inputs
`timescale 1ns/1ps
module dpar_sync
    import dpar_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// >>> design/dpar_abort_strobe.sv
// turns an accepted abort word into one-cycle strobes
`timescale 1ns/1ps
module dpar_abort_strobe
    import dpar_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic take_in,
    input wire logic [31:0] word_in,
    output logic abort_out,
    output logic orun_clr_out,
    output logic wde_clr_out,
    output logic stk_clr_out
);
    // nothing is stored: each strobe lasts exactly one cycle after the write
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            abort_out <= DPAR_STROBE_RST;
            orun_clr_out <= DPAR_STROBE_RST;
            wde_clr_out <= DPAR_STROBE_RST;
            stk_clr_out <= DPAR_STROBE_RST;
        end
        else
        begin
            abort_out <= take_in && word_in[DPAR_ABT_TRANS_BIT];
            orun_clr_out <= take_in && word_in[DPAR_ABT_ORUN_BIT];
            wde_clr_out <= take_in && word_in[DPAR_ABT_WDE_BIT];
            stk_clr_out <= take_in && word_in[DPAR_ABT_STK_BIT];
        end
    end
endmodule

// >>> design/dpar_regs.sv
// abort control, identification and base pointer registers at offset zero
// Function
// - abort write drives access port abort output
// - scan chain link uses dedicated abort chain
// - serial link aborts via write to offset zero
// - bit 4 clears overrun sticky flag
// - bit 3 clears write data error flag
// - bit 2 clears sticky error flag
// - bit 0 aborts current access port transaction
// - identification read-only with revision, part, designer
// - identification bit 16 reads one
// - identification bits 15 to 12 read 0011
// - second identification bit 7 reads one
// - second identification bits 6:0 give address width
// - base low 31:12 from base tie-off
// - base low bits 11:1 read zero
// - base low bit 0 shows valid tie-off
// - base high always reads zero
// - bank select picks offset zero read register
`timescale 1ns/1ps
module dpar_regs
    import dpar_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // 1: serial wire engine owns the bank, 0: scan chain engine
    input wire logic link_is_serial_in,
    // debug port register access from the protocol engine
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [3:0] bank_select_field_in,
    // update of the dedicated abort scan chain
    input wire logic scan_abort_wr_in,
    input wire logic [31:0] scan_abort_data_in,
    // tie-offs, resynchronised
    input wire logic [19:0] base_address_field_in,
    input wire logic base_valid_in,
    output logic access_port_abort_out,
    output logic overrun_flag_clear_out,
    output logic write_data_error_clear_out,
    output logic sticky_error_clear_out,
    output logic [31:0] reg_rdata_out,
    output logic reg_rvalid_out
);
    logic serial_take_w;
    logic scan_take_w;
    logic abort_take_w;
    logic [31:0] abort_word_w;
    logic rd_take_w;
    logic [20:0] base_sync_w;
    logic [31:0] base_lo_word_w;
    logic [31:0] rdata_nxt;

    // tie-offs may come from another domain, so resynchronise them
    dpar_sync #(
        .W(21)
    ) u_base_sync (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .async_in({base_address_field_in, base_valid_in}),
        .sync_out(base_sync_w)
    );

    // serial link reaches abort by an offset zero write
    assign serial_take_w = link_is_serial_in && reg_wr_in
        && (reg_addr_in == DPAR_OFS_ZERO);

    // scan link only through its own chain; offset zero writes land nowhere
    assign scan_take_w = !link_is_serial_in && scan_abort_wr_in;

    // any offset zero register write other than abort is dropped here
    assign abort_take_w = serial_take_w || scan_take_w;
    assign abort_word_w = serial_take_w ? reg_wdata_in : scan_abort_data_in;

    // strobes to the access ports and control/status register
    dpar_abort_strobe u_abort (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .take_in(abort_take_w),
        .word_in(abort_word_w),
        .abort_out(access_port_abort_out),
        .orun_clr_out(overrun_flag_clear_out),
        .wde_clr_out(write_data_error_clear_out),
        .stk_clr_out(sticky_error_clear_out)
    );

    // reads of other offsets belong to the rest of the bank
    assign rd_take_w = reg_rd_in && (reg_addr_in == DPAR_OFS_ZERO);

    // bits 11:1 below the address are forced to zero, the valid bit sits at 0
    assign base_lo_word_w = {base_sync_w[20:1], DPAR_BASE_LOW_ZERO,
        base_sync_w[0]};

    // bank select steers the read; unused banks read zero
    always_comb
    begin
        rdata_nxt = DPAR_RDATA_RST;
        unique case (bank_select_field_in)
            DPAR_BANK_IDR:
            begin
                rdata_nxt = DPAR_IDR_WORD;
            end
            DPAR_BANK_IDR_EXT:
            begin
                rdata_nxt = DPAR_IDR_EXT_WORD;
            end
            DPAR_BANK_BASE_LO:
            begin
                rdata_nxt = base_lo_word_w;
            end
            DPAR_BANK_BASE_HI:
            begin
                rdata_nxt = DPAR_BASE_HI_WORD;
            end
            default:
            begin
                rdata_nxt = DPAR_RDATA_RST;
            end
        endcase
    end

    // read data registered; held between reads so the engine may shift it late
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out <= DPAR_RDATA_RST;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= rd_take_w;
            if (rd_take_w)
            begin
                reg_rdata_out <= rdata_nxt;
            end
        end
    end

    // checks of the register behaviour
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    property p_abort_serial;
        link_is_serial_in && reg_wr_in && reg_addr_in == DPAR_OFS_ZERO
            && reg_wdata_in[0] |=> access_port_abort_out;
    endproperty
    a_abort_serial: assert property (p_abort_serial)
        else $error("serial abort write gave no abort");

    property p_abort_scan;
        !link_is_serial_in && scan_abort_wr_in && scan_abort_data_in[0]
            |=> access_port_abort_out;
    endproperty
    a_abort_scan: assert property (p_abort_scan)
        else $error("scan chain abort gave no abort");

    property p_scan_reg_write_ignored;
        !link_is_serial_in && reg_wr_in && !scan_abort_wr_in
            |=> !access_port_abort_out && !sticky_error_clear_out;
    endproperty
    a_scan_reg_write_ignored: assert property (p_scan_reg_write_ignored)
        else $error("register write on scan link acted as abort");

    property p_abort_cause;
        access_port_abort_out |-> $past(abort_take_w && abort_word_w[0]);
    endproperty
    a_abort_cause: assert property (p_abort_cause)
        else $error("abort raised without abort write");

    property p_abort_one_cycle;
        access_port_abort_out && !$past(abort_take_w, 2)
            |=> !access_port_abort_out || $past(abort_take_w);
    endproperty
    a_abort_one_cycle: assert property (p_abort_one_cycle)
        else $error("abort held without a new write");

    property p_abort_bit0;
        abort_take_w && abort_word_w[DPAR_ABT_TRANS_BIT]
            ##1 !abort_take_w |=> !access_port_abort_out;
    endproperty
    a_abort_bit0: assert property (p_abort_bit0)
        else $error("abort strobe longer than one cycle");

    property p_orun_clear;
        abort_take_w && abort_word_w[4] |=> overrun_flag_clear_out;
    endproperty
    a_orun_clear: assert property (p_orun_clear)
        else $error("bit 4 write did not clear overrun flag");

    property p_wde_clear;
        abort_take_w && abort_word_w[3] |=> write_data_error_clear_out;
    endproperty
    a_wde_clear: assert property (p_wde_clear)
        else $error("bit 3 write did not clear write data error");

    property p_stk_clear;
        abort_take_w && abort_word_w[2] |=> sticky_error_clear_out;
    endproperty
    a_stk_clear: assert property (p_stk_clear)
        else $error("bit 2 write did not clear sticky error");

    property p_zero_no_effect;
        !abort_take_w || abort_word_w[4:2] == 3'h0
            |=> !overrun_flag_clear_out && !write_data_error_clear_out
            && !sticky_error_clear_out;
    endproperty
    a_zero_no_effect: assert property (p_zero_no_effect)
        else $error("clear strobe without a one written");

    property p_idr_word;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR
            |=> reg_rvalid_out && reg_rdata_out[31:28] == DPAR_ID_REVISION
            && reg_rdata_out[27:20] == DPAR_ID_PART
            && reg_rdata_out[11:1] == DPAR_ID_DESIGNER;
    endproperty
    a_idr_word: assert property (p_idr_word)
        else $error("identification fields wrong");

    property p_idr_min;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR
            |=> reg_rdata_out[DPAR_ID_MIN_BIT] == 1'b1;
    endproperty
    a_idr_min: assert property (p_idr_min)
        else $error("identification bit 16 not one");

    property p_idr_version;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR
            |=> reg_rdata_out[15:12] == 4'h3 && reg_rdata_out[0] == 1'b1;
    endproperty
    a_idr_version: assert property (p_idr_version)
        else $error("architecture version or bit 0 wrong");

    property p_idr_const;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR
            ##1 rd_take_w && bank_select_field_in == DPAR_BANK_IDR
            |=> reg_rdata_out == $past(reg_rdata_out);
    endproperty
    a_idr_const: assert property (p_idr_const)
        else $error("identification value changed");

    property p_ext_error_reporting_mode;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR_EXT
            |=> reg_rdata_out[DPAR_ERR_REPORT_BIT] == 1'b1
            && reg_rdata_out[31:8] == 24'h000000;
    endproperty
    a_ext_error_reporting_mode: assert property (p_ext_error_reporting_mode)
        else $error("error mode support bit wrong");

    property p_ext_awidth;
        rd_take_w && bank_select_field_in == DPAR_BANK_IDR_EXT
            |=> reg_rdata_out[6:0] == 7'h0c || reg_rdata_out[6:0] == 7'h14
            || reg_rdata_out[6:0] == 7'h20;
    endproperty
    a_ext_awidth: assert property (p_ext_awidth)
        else $error("address width code reserved");

    property p_base_lo;
        rd_take_w && bank_select_field_in == DPAR_BANK_BASE_LO
            |=> reg_rdata_out[31:12] == $past(base_sync_w[20:1])
            && reg_rdata_out[0] == $past(base_sync_w[0]);
    endproperty
    a_base_lo: assert property (p_base_lo)
        else $error("base pointer does not follow tie-off");

    property p_base_tie_path;
        $stable(base_address_field_in) [*3] ##0 rd_take_w
            && bank_select_field_in == DPAR_BANK_BASE_LO
            |=> reg_rdata_out[31:12] == $past(base_address_field_in);
    endproperty
    a_base_tie_path: assert property (p_base_tie_path)
        else $error("settled base tie-off not returned");

    property p_base_low_zero;
        rd_take_w && bank_select_field_in == DPAR_BANK_BASE_LO
            |=> reg_rdata_out[11:1] == 11'h000;
    endproperty
    a_base_low_zero: assert property (p_base_low_zero)
        else $error("base pointer low bits not zero");

    property p_base_valid;
        $stable(base_valid_in) [*3] ##0 rd_take_w
            && bank_select_field_in == DPAR_BANK_BASE_LO
            |=> reg_rdata_out[DPAR_BASE_VALID_BIT] == $past(base_valid_in);
    endproperty
    a_base_valid: assert property (p_base_valid)
        else $error("base valid bit wrong");

    property p_base_hi;
        rd_take_w && bank_select_field_in == DPAR_BANK_BASE_HI
            |=> reg_rdata_out == 32'h00000000;
    endproperty
    a_base_hi: assert property (p_base_hi)
        else $error("base high not zero");

    property p_rvalid_cause;
        reg_rvalid_out |-> $past(reg_rd_in && reg_addr_in == 2'h0);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read answer without offset zero read");

    property p_reserved_bank;
        rd_take_w && bank_select_field_in > DPAR_BANK_BASE_HI
            |=> reg_rvalid_out && reg_rdata_out == 32'h00000000;
    endproperty
    a_reserved_bank: assert property (p_reserved_bank)
        else $error("reserved bank did not read zero");

    property p_rdata_hold;
        !rd_take_w |=> $stable(reg_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    // while the serial engine owns the bank the abort chain must stay silent
    property p_scan_ignored_serial;
        link_is_serial_in && !(reg_wr_in && reg_addr_in == DPAR_OFS_ZERO)
            |=> !access_port_abort_out && !overrun_flag_clear_out
            && !write_data_error_clear_out && !sticky_error_clear_out;
    endproperty
    a_scan_ignored_serial: assert property (p_scan_ignored_serial)
        else $error("abort chain acted while serial link owns the bank");

    property p_wr_other_offset;
        reg_wr_in && reg_addr_in != DPAR_OFS_ZERO && !scan_abort_wr_in
            |=> !access_port_abort_out && !overrun_flag_clear_out
            && !write_data_error_clear_out && !sticky_error_clear_out;
    endproperty
    a_wr_other_offset: assert property (p_wr_other_offset)
        else $error("write to another offset acted as abort");

    property p_abort_zero_bit;
        abort_take_w && !abort_word_w[DPAR_ABT_TRANS_BIT] |=> !access_port_abort_out;
    endproperty
    a_abort_zero_bit: assert property (p_abort_zero_bit)
        else $error("abort raised by a zero in bit 0");

    property p_rd_other_offset;
        reg_rd_in && reg_addr_in != DPAR_OFS_ZERO |=> !reg_rvalid_out && $stable(reg_rdata_out);
    endproperty
    a_rd_other_offset: assert property (p_rd_other_offset)
        else $error("read of another offset answered");
endmodule

// >>> tb/dpar_flag_model.sv
// model of the control/status flags and access port that sit behind the abort strobes
`timescale 1ns/1ps
module dpar_flag_model (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] flag_set_in,
    input wire logic abort_in,
    input wire logic orun_clr_in,
    input wire logic wde_clr_in,
    input wire logic stk_clr_in,
    output logic [2:0] flags_out,
    output logic [7:0] abort_count_out
);
    // sticky flags {overrun, write data error, sticky error}; clear wins over a same-cycle set
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            flags_out <= 3'h0;
        end
        else
        begin
            flags_out <= (flags_out | flag_set_in) & ~{orun_clr_in, wde_clr_in, stk_clr_in};
        end
    end

    // one abandoned transfer per pulse; a stretched or doubled pulse shows up in the count
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            abort_count_out <= 8'h00;
        end
        else
        begin
            abort_count_out <= abort_count_out + {7'h00, abort_in};
        end
    end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the abort, identification and base pointer registers
`timescale 1ns/1ps
module testbench;
    import dpar_pkg::*;
    logic clk_sys_in, sys_rst_in, link_is_serial_in, reg_wr_in, reg_rd_in, scan_abort_wr_in, base_valid_in;
    logic [1:0] reg_addr_in;
    logic [31:0] reg_wdata_in, scan_abort_data_in, reg_rdata_out, last_rd;
    logic [3:0] bank_select_field_in;
    logic [19:0] base_address_field_in;
    logic access_port_abort_out, overrun_flag_clear_out, write_data_error_clear_out, sticky_error_clear_out;
    logic reg_rvalid_out;
    logic [2:0] flag_set, flags;
    logic [7:0] abort_count;
    logic [3:0] strb;
    int n_fail, check_count, exp_aborts;
    logic [31:0] corner [7] = '{32'h1, 32'h4, 32'h8, 32'h10, 32'h1d, 32'h0, 32'hffffffe2};

    // strobe vector order {abort, overrun clear, write data clear, sticky clear}
    assign strb = {access_port_abort_out, overrun_flag_clear_out, write_data_error_clear_out, sticky_error_clear_out};

    dpar_regs u_dpar_regs (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link_is_serial_in(link_is_serial_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .bank_select_field_in(bank_select_field_in), .scan_abort_wr_in(scan_abort_wr_in),
        .scan_abort_data_in(scan_abort_data_in), .base_address_field_in(base_address_field_in),
        .base_valid_in(base_valid_in), .access_port_abort_out(access_port_abort_out),
        .overrun_flag_clear_out(overrun_flag_clear_out), .write_data_error_clear_out(write_data_error_clear_out),
        .sticky_error_clear_out(sticky_error_clear_out), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out));

    dpar_flag_model u_dpar_flag_model (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .flag_set_in(flag_set),
        .abort_in(access_port_abort_out), .orun_clr_in(overrun_flag_clear_out),
        .wde_clr_in(write_data_error_clear_out), .stk_clr_in(sticky_error_clear_out), .flags_out(flags),
        .abort_count_out(abort_count));

    // 250 MHz system clock
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // expected offset-zero read word per bank, built from the field layout
    function automatic logic [31:0] exp_read(input logic [3:0] bank);
        case (bank)
            4'h0: return {DPAR_ID_REVISION, DPAR_ID_PART, 3'h0, 1'b1, 4'h3, DPAR_ID_DESIGNER, 1'b1};
            4'h1: return {24'h000000, 1'b1, 7'h20};
            4'h2: return {base_address_field_in, 11'h000, base_valid_in};
            default: return 32'h00000000;
        endcase
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_strb(input logic [3:0] got, input logic [3:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one read pulse; valid and data one cycle later, data held the cycle after
    task automatic do_read(input logic [1:0] addr, input logic [3:0] bank);
        logic [31:0] e;
        e = exp_read(bank);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= addr;
        bank_select_field_in <= bank;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        if (addr == 2'h0)
        begin
            last_rd = e;
        end
        #1;
        chk_strb({3'h0, reg_rvalid_out}, {3'h0, addr == 2'h0}, "read valid");
        chk_word(reg_rdata_out, last_rd, "read data");
        @(posedge clk_sys_in);
        #1;
        chk_strb({3'h0, reg_rvalid_out}, 4'h0, "valid one cycle");
        chk_word(reg_rdata_out, last_rd, "read data held");
    endtask

    // abort word through either link; flags are raised first so the clears can be seen
    task automatic do_write(input logic serial, input logic scan, input logic [1:0] addr, input logic [31:0] d);
        logic [3:0] e;
        e = 4'h0;
        if (scan ? !serial : (serial && addr == 2'h0))
        begin
            e = {d[0], d[4], d[3], d[2]};
        end
        @(posedge clk_sys_in);
        link_is_serial_in <= serial;
        flag_set <= 3'h7;
        scan_abort_wr_in <= scan;
        scan_abort_data_in <= d;
        reg_wr_in <= !scan;
        reg_addr_in <= addr;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        scan_abort_wr_in <= 1'b0;
        flag_set <= 3'h0;
        #1;
        chk_strb(strb, e, "strobes");
        exp_aborts += e[3];
        @(posedge clk_sys_in);
        #1;
        chk_strb(strb, 4'h0, "strobes one cycle");
        chk_strb({1'b0, flags}, {1'b0, 3'h7 & ~e[2:0]}, "flags after clear");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard: a run this long means a stuck sequence
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test;
    end

    initial
    begin
        sys_rst_in = 1'b1;
        link_is_serial_in = 1'b1;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 2'h0;
        reg_wdata_in = 32'h00000000;
        bank_select_field_in = 4'h0;
        scan_abort_wr_in = 1'b0;
        scan_abort_data_in = 32'h00000000;
        base_address_field_in = 20'h00000;
        base_valid_in = 1'b0;
        flag_set = 3'h0;
        last_rd = 32'h00000000;
        n_fail = 0;
        check_count = 0;
        exp_aborts = 0;
        void'($urandom(32'h66c3b207));
        repeat (9) @(posedge clk_sys_in);
        #1;
        chk_strb(strb | {3'h0, reg_rvalid_out}, 4'h0, "outputs in reset");
        chk_word(reg_rdata_out, 32'h00000000, "read data in reset");
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        // every bank at offset zero, then refused places and ignored writes
        for (int i = 0; i < 16; i++)
        begin
            do_read(2'h0, i[3:0]);
        end
        do_read(2'h1, 4'h0);
        do_write(1'b1, 1'b0, 2'h2, 32'h0000001f);
        do_read(2'h0, 4'h0);
        // two identification reads on consecutive edges; both are answered
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= 2'h0;
        bank_select_field_in <= 4'h0;
        repeat (2) @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        last_rd = exp_read(4'h0);
        #1;
        chk_strb({3'h0, reg_rvalid_out}, 4'h1, "back-to-back valid");
        chk_word(reg_rdata_out, last_rd, "back-to-back data");
        $display("test id_banks done");
        // random tie-offs, with empty valid and all-ones pointer as corners
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk_sys_in);
            base_address_field_in <= (k == 1) ? 20'hfffff : 20'($urandom);
            base_valid_in <= (k == 0) ? 1'b0 : 1'($urandom);
            repeat (3) @(posedge clk_sys_in);
            do_read(2'h0, 4'h2);
            do_read(2'h0, 4'h3);
        end
        $display("test base_pointer done");
        // every link and mode pairing with corner words then random words
        for (int m = 0; m < 4; m++)
        begin
            for (int j = 0; j < 11; j++)
            begin
                do_write(m[0], m[1], 2'h0, (j < 7) ? corner[j] : $urandom);
            end
        end
        chk_word({24'h000000, abort_count}, 32'(exp_aborts), "abort pulse count");
        $display("test abort_links done");
        finish_test;
    end
endmodule
